//--- ldsc_top.sv
// LED driver control core: command registers, standby and soft start.
// Assumes a host on the serial pins; currents are reported in mA codes.
`timescale 1ns/1ns
`default_nettype none
`include "ldsc_cfg.svh"
module ldsc_top
  import ldsc_pkg::*;
#(
  parameter int unsigned SOFT_START_CYC =
    `LDSC_SOFT_START_NS / `LDSC_CLK_PERIOD_NS
)(
  input  wire logic        CORE_CLK,
  input  wire logic        ARST_N,
  input  wire logic        SER_EN,
  input  wire logic        SER_CLK,
  input  wire logic        SER_DAT,
  input  wire logic        SUPPLY_LOSS_RESET_N,
  output logic [47:0]      LED_MA,
  output logic [7:0]       FLASH_MA,
  output logic             LDO_ON,
  output logic             PUMP_ON,
  output logic             STANDBY,
  output logic             SOFT_START_BUSY
);
  ldsc_word_if w ();

  ldsc_rx u_rx (
    .core_clk (CORE_CLK),
    .arst_n   (ARST_N),
    .ser_en   (SER_EN),
    .ser_clk  (SER_CLK),
    .ser_dat  (SER_DAT),
    .w        (w)
  );

  // Backlight step: 2mA per step at full range, 1mA at half range
  function automatic logic [7:0] bl_ma(ldsc_nib_t dim, logic half);
    bl_ma = half ? {4'h0, dim} : {3'h0, dim, 1'b0};
  endfunction

  function automatic logic [7:0] fl_ma(ldsc_nib_t dim, logic half);
    fl_ma = {4'h0, dim} * (half ? 8'h05 : 8'h0A);
  endfunction

  logic [2:0]  rs_q;
  logic        rflt_q;
  ldsc_nib_t   grp_q, dim_a_q, dim_b_q, dim_f_q, on_q, sys_q;
  ldsc_state_t state_q, state_d;
  logic [17:0] ss_cnt_q, ss_cnt_d;
  logic [47:0] led_d;
  logic [7:0]  flash_d;

  // Supply-loss pin through three stages; low once late stages agree
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rs_q   <= 3'h0;
      rflt_q <= 1'b0;
    end else begin
      rs_q   <= {rs_q[1:0], SUPPLY_LOSS_RESET_N};
      rflt_q <= (rs_q[1] == rs_q[2]) ? rs_q[2] : rflt_q;
    end
  end

  wire        pin_rst = ~rflt_q;
  wire        wr      = w.valid;
  wire [3:0]  adr     = w.word[7:4];
  wire [3:0]  dat     = w.word[3:0];
  wire        clr     = pin_rst || (wr && adr == `LDSC_ADR_RESET);
  wire        any_led = on_q[`LDSC_ON_A] | on_q[`LDSC_ON_B] | on_q[`LDSC_ON_F];
  wire        lit     = state_q == LDSC_ACTIVE;
  // Grouping code g moves the last g-1 channels to B, at most five
  wire [3:0]  b_cnt   = (grp_q == 4'h0) ? 4'h0 :
                        (grp_q > 4'h6) ? 4'h5 : grp_q - 4'h1;

  // Each write lands immediately, so writes apply in arrival order
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      grp_q   <= `LDSC_REG_RST;
      dim_a_q <= `LDSC_REG_RST;
      dim_b_q <= `LDSC_REG_RST;
      dim_f_q <= `LDSC_REG_RST;
      on_q    <= `LDSC_REG_RST;
      sys_q   <= `LDSC_REG_RST;
    end else if (clr) begin
      grp_q   <= `LDSC_REG_RST;
      dim_a_q <= `LDSC_REG_RST;
      dim_b_q <= `LDSC_REG_RST;
      dim_f_q <= `LDSC_REG_RST;
      on_q    <= `LDSC_REG_RST;
      sys_q   <= `LDSC_REG_RST;
    end else if (wr) begin
      case (adr)
        `LDSC_ADR_GROUP: grp_q   <= dat;
        `LDSC_ADR_DIM_A: dim_a_q <= dat;
        `LDSC_ADR_DIM_B: dim_b_q <= dat;
        `LDSC_ADR_DIM_F: dim_f_q <= dat;
        `LDSC_ADR_ON:    on_q    <= dat;
        `LDSC_ADR_SYS:   sys_q   <= dat;
        default:         grp_q   <= grp_q;
      endcase
    end
  end

  always_comb begin
    state_d  = state_q;
    ss_cnt_d = ss_cnt_q;
    case (state_q)
      LDSC_STANDBY: begin
        ss_cnt_d = 18'h00000;
        if (any_led)
          state_d = LDSC_SOFT;
      end
      LDSC_SOFT: begin
        ss_cnt_d = ss_cnt_q + 18'h00001;
        if (!any_led)
          state_d = LDSC_STANDBY;
        else if (ss_cnt_q == 18'(SOFT_START_CYC - 1))
          state_d = LDSC_ACTIVE;
      end
      LDSC_ACTIVE: begin
        if (!any_led)
          state_d = LDSC_STANDBY;
      end
      default: state_d = LDSC_STANDBY;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q  <= LDSC_STANDBY;
      ss_cnt_q <= 18'h00000;
    end else begin
      state_q  <= state_d;
      ss_cnt_q <= ss_cnt_d;
    end
  end

  // Channel i sits in B when i >= 6 - b_cnt; dark unless soft start done
  always_comb begin
    led_d = 48'h0;
    for (int i = 0; i < 6; i++) begin
      if (i >= 6 - int'(b_cnt)) begin
        if (lit && on_q[`LDSC_ON_B])
          led_d[i*8 +: 8] = bl_ma(dim_b_q, sys_q[`LDSC_SYS_B]);
      end else if (lit && on_q[`LDSC_ON_A]) begin
        led_d[i*8 +: 8] = bl_ma(dim_a_q, sys_q[`LDSC_SYS_A]);
      end
    end
    flash_d = (lit && on_q[`LDSC_ON_F]) ?
              fl_ma(dim_f_q, sys_q[`LDSC_SYS_F]) : 8'h00;
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      LED_MA   <= 48'h0;
      FLASH_MA <= 8'h00;
      LDO_ON   <= 1'b0;
    end else begin
      LED_MA   <= led_d;
      FLASH_MA <= flash_d;
      LDO_ON   <= on_q[`LDSC_ON_LDO];
    end
  end

  assign PUMP_ON         = state_q != LDSC_STANDBY;
  assign STANDBY         = state_q == LDSC_STANDBY;
  assign SOFT_START_BUSY = state_q == LDSC_SOFT;

  property p_grp13;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (wr && w.word == 8'h13 && !pin_rst) |=> grp_q == 4'h3;
  endproperty
  a_grp13: assert property (p_grp13)
    else $error("grouping word not applied");

  property p_dim25;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (wr && w.word == 8'h25 && !pin_rst) |=> dim_a_q == 4'h5;
  endproperty
  a_dim25: assert property (p_dim25)
    else $error("group A dimming not set to five");

  property p_dim3a;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (wr && w.word == 8'h3A && !pin_rst && !sys_q[2] && lit
       && on_q[2] && grp_q == 4'h3)
      |=> ##1 LED_MA[47:40] == 8'h14;
  endproperty
  a_dim3a: assert property (p_dim3a)
    else $error("group B not at 20mA");

  property p_on5c;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (wr && w.word == 8'h5C && !pin_rst) |=> (on_q[3] && on_q[2]);
  endproperty
  a_on5c: assert property (p_on5c)
    else $error("groups A and B not both on");

  property p_dark;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (state_q != LDSC_ACTIVE) |=> LED_MA == 48'h0;
  endproperty
  a_dark: assert property (p_dark)
    else $error("LEDs lit before soft start ends");

  // Counter steps once more on the edge that enters ACTIVE, then holds
  property p_ss_len;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      $rose(state_q == LDSC_ACTIVE) |-> ss_cnt_q == 18'(SOFT_START_CYC);
  endproperty
  a_ss_len: assert property (p_ss_len)
    else $error("soft start length wrong");

  property p_full_a;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (lit && grp_q == 4'h0 && dim_a_q == 4'hF && !sys_q[3] && on_q[3])
      |=> LED_MA == {6{8'h1E}};
  endproperty
  a_full_a: assert property (p_full_a)
    else $error("six channels not at 30mA");

  property p_off50;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (wr && w.word == 8'h50 && on_q[1] == 1'b0) |=> ##1 STANDBY;
  endproperty
  a_off50: assert property (p_off50)
    else $error("standby not entered");

  property p_keep;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (STANDBY && !wr && !pin_rst) |=> $stable(dim_a_q) && $stable(dim_b_q);
  endproperty
  a_keep: assert property (p_keep)
    else $error("dimming lost in standby");

  property p_pinrst;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      pin_rst |=> (on_q == 4'h0 && dim_a_q == 4'h0 && grp_q == 4'h0)
      ##1 (STANDBY && LED_MA == 48'h0);
  endproperty
  a_pinrst: assert property (p_pinrst)
    else $error("reset pin did not clear");

  property p_half;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (lit && grp_q == 4'h0 && on_q[3] && sys_q[3])
      |=> LED_MA[7:0] == {4'h0, $past(dim_a_q)};
  endproperty
  a_half: assert property (p_half)
    else $error("half range current wrong");
endmodule // ldsc_top
`default_nettype wire

//--- ldsc_cfg.svh
// Constants of the LED driver serial control block: addresses, fields,
// reset values and timing. Included by ldsc_top and ldsc_rx of the block.
//
// What this block does
// - Word 13H puts channels one to four in group A, five and six in B.
// - Word 25H sets group A dimming to five, 10mA at 30mA range.
// - Word 3AH sets group B dimming to ten, 20mA at 30mA range.
// - One word per enable cycle; word 5CH turns groups A and B on together.
// - Leaving standby, LEDs stay dark until the 1.3ms soft start ends.
// - Word 2FH sets group A to fifteen; 58H lights all six ungrouped.
// - Word 50H turns group A off; no group or flash on means standby.
// - Dimming settings survive standby; 58H alone relights, soft start reruns.
// - Falling supply-loss reset input clears everything, LEDs off, standby.
// - Address 5H bits enable group A, group B, flash and regulator.
// - Power-up, reset pin or reset-mode word clear all registers to zero.
// - Max-current bit picks 30mA or 15mA full scale, 150mA or 75mA for flash, dimming linear.
`ifndef LDSC_CFG_SVH
`define LDSC_CFG_SVH

`define LDSC_ADR_GROUP    4'h1
`define LDSC_ADR_DIM_A    4'h2
`define LDSC_ADR_DIM_B    4'h3
`define LDSC_ADR_DIM_F    4'h4
`define LDSC_ADR_ON       4'h5
`define LDSC_ADR_SYS      4'h6
`define LDSC_ADR_RESET    4'h7

`define LDSC_ON_A         3
`define LDSC_ON_B         2
`define LDSC_ON_F         1
`define LDSC_ON_LDO       0
`define LDSC_SYS_A        3
`define LDSC_SYS_B        2
`define LDSC_SYS_F        1

`define LDSC_REG_RST      4'h0
`define LDSC_WORD_BITS    4'h8

`define LDSC_CLK_PERIOD_NS 10
`define LDSC_SOFT_START_NS 1300000

`endif

//--- ldsc_pkg.sv
// Types shared by the LED driver serial control block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package ldsc_pkg;
  typedef enum logic [1:0] {
    LDSC_STANDBY = 2'b00,
    LDSC_SOFT    = 2'b01,
    LDSC_ACTIVE  = 2'b10
  } ldsc_state_t;
  typedef logic [3:0] ldsc_nib_t;
endpackage
`default_nettype wire

//--- ldsc_word_if.sv
// Carries one received command word from the serial receiver to the core.
// Assumes both ends sit on CORE_CLK.
`timescale 1ns/1ns
`default_nettype none
interface ldsc_word_if;
  logic [7:0] word;
  logic       valid;
  modport rx   (output word, output valid);
  modport core (input word, input valid);
endinterface
`default_nettype wire

//--- ldsc_rx.sv
// Three-wire serial receiver: enable, shift clock and data from the host.
// Assumes pins are asynchronous to CORE_CLK and far slower than it.
`timescale 1ns/1ns
`default_nettype none
`include "ldsc_cfg.svh"
module ldsc_rx
  import ldsc_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  arst_n,
  input  wire logic  ser_en,
  input  wire logic  ser_clk,
  input  wire logic  ser_dat,
  ldsc_word_if.rx    w
);
  logic [2:0] s1_q, s2_q, s3_q, f_q;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic       en_prev_q, ck_prev_q;
  logic       en_fall, ck_rise;

  // Filtered level moves only once the two late stages agree
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      f_q  <= 3'h0;
    end else begin
      s1_q <= {ser_en, ser_clk, ser_dat};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= (s2_q & s3_q) | (f_q & (s2_q | s3_q));
    end
  end

  assign en_fall = en_prev_q & ~f_q[2];
  assign ck_rise = f_q[2] & f_q[1] & ~ck_prev_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_prev_q <= 1'b0;
      ck_prev_q <= 1'b0;
      sh_q      <= 8'h00;
      cnt_q     <= 4'h0;
      w.valid   <= 1'b0;
      w.word    <= 8'h00;
    end else begin
      en_prev_q <= f_q[2];
      ck_prev_q <= f_q[1];
      w.valid   <= en_fall && cnt_q == `LDSC_WORD_BITS;
      if (en_fall)
        w.word <= sh_q;
      if (!f_q[2])
        cnt_q <= 4'h0;
      else if (ck_rise) begin
        sh_q  <= {sh_q[6:0], f_q[0]};
        // Saturates at fifteen so an overlong frame is dropped
        cnt_q <= (cnt_q == 4'hF) ? cnt_q : cnt_q + 4'h1;
      end
    end
  end

  property p_apply;
    @(posedge core_clk) disable iff (!arst_n)
      (en_fall && cnt_q == 4'h8) |=> (w.valid && w.word == $past(sh_q));
  endproperty
  a_apply: assert property (p_apply)
    else $error("complete word not applied on enable fall");

  property p_short;
    @(posedge core_clk) disable iff (!arst_n)
      (en_fall && cnt_q != 4'h8) |=> !w.valid;
  endproperty
  a_short: assert property (p_short)
    else $error("partial word applied");
endmodule // ldsc_rx
`default_nettype wire

//--- ldsc_host_model.sv
// Host side of the three-wire serial link, one word per enable cycle.
// Assumes clk is the core clock; pins change every six cycles, ten after enable falls.
`timescale 1ns/1ns
`default_nettype none
module ldsc_host_model (
  input  wire logic clk,
  output logic      ser_en,
  output logic      ser_clk,
  output logic      ser_dat
);
  initial begin
    ser_en  = 1'b0;
    ser_clk = 1'b0;
    ser_dat = 1'b0;
  end
  task automatic hold(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Any n other than 8 makes a deliberately bad frame
  task automatic send(input logic [7:0] w, input int n);
    ser_en = 1'b1;
    hold(6);
    for (int i = 0; i < n; i++) begin
      ser_dat = w[(7 - i) & 7];
      hold(6);
      ser_clk = 1'b1;
      hold(6);
      ser_clk = 1'b0;
    end
    hold(6);
    ser_en = 1'b0;
    // Released data must not keep showing its last value
    ser_dat = ~ser_dat;
    hold(10);
  endtask
endmodule // ldsc_host_model
`default_nettype wire

//--- tb_led_driver_serial_control.sv
// Self-checking bench of the LED driver serial control core.
// Assumes ldsc_host_model drives the serial pins.
`timescale 1ns/1ns
`default_nettype none
module tb_led_driver_serial_control;
  localparam int unsigned SS = 40;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        sup_n = 1'b1;
  wire logic   s_en;
  wire logic   s_clk;
  wire logic   s_dat;
  logic [47:0] led;
  logic [7:0]  flash;
  logic        ldo;
  logic        pump;
  logic        stby;
  logic        busy;
  int          miscompares = 0;
  int          tests_run = 0;
  int          seed = 32'he0c66ca5;
  logic [3:0]  d;
  logic        m;
  always #5 clk = ~clk;
  ldsc_host_model host_u (.clk(clk), .ser_en(s_en), .ser_clk(s_clk),
    .ser_dat(s_dat));
  ldsc_top #(.SOFT_START_CYC(SS)) dut_u (.CORE_CLK(clk), .ARST_N(arst_n),
    .SER_EN(s_en), .SER_CLK(s_clk), .SER_DAT(s_dat),
    .SUPPLY_LOSS_RESET_N(sup_n), .LED_MA(led), .FLASH_MA(flash),
    .LDO_ON(ldo), .PUMP_ON(pump), .STANDBY(stby), .SOFT_START_BUSY(busy));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] w);
    host_u.send(w, 8);
    cyc(2);
  endtask
  // Bounded wait for the soft start to finish
  task automatic wait_lit();
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 200) begin
      cyc(1);
      i++;
    end
    if (i == 200) begin
      miscompares++;
      end_of_test();
    end
    cyc(2);
  endtask
  // Channel currents from grouping, dimming, half-scale and on bits
  function automatic logic [47:0] exp_led(input logic [3:0] g, da, db,
      input logic ma, mb, ea, eb);
    logic [47:0] r;
    int nb;
    nb = (g == 4'h0) ? 0 : ((g > 4'h6) ? 5 : int'(g) - 1);
    for (int c = 0; c < 6; c++) begin
      if (c >= 6 - nb) r[c*8 +: 8] = eb ? 8'(db * (mb ? 1 : 2)) : 8'h00;
      else r[c*8 +: 8] = ea ? 8'(da * (ma ? 1 : 2)) : 8'h00;
    end
    return r;
  endfunction
  initial begin
    cyc(20);
    arst_n = 1'b1;
    cyc(10);
    chk(64'({stby, pump, ldo, busy, flash, led}), 64'({4'h8, 56'h0}));
    $display("test reset state done");
    wr(8'h2F);
    wr(8'h58);
    chk(56'({busy, led}), 56'({1'b1, 48'h0}));
    wait_lit();
    chk(56'({stby, pump, led}), 56'({2'b01,
      exp_led(4'h0, 4'hF, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0)}));
    $display("test ungrouped full current done");
    wr(8'h50);
    chk(56'({stby, pump, led}), 56'({2'b10, 48'h0}));
    wr(8'h58);
    chk(56'({busy, led}), 56'({1'b1, 48'h0}));
    wait_lit();
    chk(56'(led), 56'(exp_led(4'h0, 4'hF, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0)));
    $display("test standby and relight done");
    wr(8'h70);
    wr(8'h13);
    wr(8'h25);
    wr(8'h3A);
    wr(8'h5C);
    wait_lit();
    chk(56'(led), 56'(exp_led(4'h3, 4'h5, 4'hA, 1'b0, 1'b0, 1'b1, 1'b1)));
    // Rewrite B dimming while lit so the group B current check is reached
    wr(8'h3A);
    chk(56'(led),
      56'(exp_led(4'h3, 4'h5, 4'hA, 1'b0, 1'b0, 1'b1, 1'b1)));
    $display("test two groups done");
    wr(8'h6C);
    wr(8'h43);
    wr(8'h5E);
    chk({busy, 7'h00, flash, led}, {8'h00, 8'h1E,
      exp_led(4'h3, 4'h5, 4'hA, 1'b1, 1'b1, 1'b1, 1'b1)});
    $display("test half scale and flash done");
    wr(8'h51);
    chk(64'({stby, pump, ldo, flash, led}), 64'({3'b101, 56'h0}));
    // Both bad frames leave 58H in the shifter, so taking one would light A
    for (int n = 9; n >= 7; n -= 2) begin
      host_u.send((n == 9) ? 8'h2C : 8'hB0, n);
      cyc(2);
      chk(56'({stby, led}), 56'({1'b1, 48'h0}));
    end
    $display("test enable register and bad frames done");
    wr(8'h70);
    wr(8'h58);
    wait_lit();
    repeat (6) begin
      d = 4'($random(seed));
      m = 1'($random(seed));
      wr({4'h6, m, 3'h0});
      wr({4'h2, ~d});
      wr({4'h2, d});
      chk(56'(led), 56'(exp_led(4'h0, d, 4'h0, m, 1'b0, 1'b1, 1'b0)));
    end
    $display("test random dimming done");
    sup_n = 1'b0;
    cyc(12);
    chk(56'({stby, pump, led}), 56'({2'b10, 48'h0}));
    sup_n = 1'b1;
    cyc(10);
    wr(8'h58);
    wait_lit();
    chk(56'({stby, led}), 56'h0);
    $display("test supply loss reset done");
    end_of_test();
  end
endmodule // tb_led_driver_serial_control
`default_nettype wire
